// ---- verilog/ukls_dev.sv ----
// Device end: user K-block pass-through, link status and reset handling
// Function
// - App asserts valid with block number 0-8
// - Data moves only after ready is given
// - K ready withdraws normal data ready
// - TX word: zero nibble, number, payload
// - App valid only with valid block
// - Ready only when block can be taken
// - RX valid while received block presented
// - RX word: zero nibble, number, data
// - Blocks undecoded; K paths per build direction
// - Channel up after init, both directions
// - Per-lane up bits gate received data
// - Hard error held until core reset
// - Soft error pulses one clock
// - Core reset debounced over six clocks
// - PMA init debounced over six ticks
// - Power-down forwarded to transceiver
// - Init clock runs transceiver reset sequencing
module ukls_dev
  import ukls_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // User side
  ukls_if.dev                    lk,
  // Lane and transceiver side
  input  wire logic              init_clk_i,
  input  wire logic [LANES-1:0]  lane_ok_i,
  input  wire logic              lane_busy_i,
  input  wire logic              lane_rx_vld_i,
  input  wire logic [LW-1:0]     lane_rx_dat_i,
  input  wire logic              hard_evt_i,
  input  wire logic              soft_evt_i,
  output logic                   lane_tx_vld_o,
  output logic [LW-1:0]          lane_tx_dat_o,
  output logic                   gt_pdn_o,
  output logic                   pcs_pma_rst_o,
  output logic                   clkgen_rst_o,
  output logic                   gt_tx_rst_o,
  output logic                   gt_rx_rst_o
);
  import ukls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Core reset debounce
  logic [DEB_CYCLES-1:0] deb_reg;
  logic                  core_rst_reg;
  wire                   deb_full = &deb_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deb_reg      <= '0;
      core_rst_reg <= 1'b1;
    end else begin
      deb_reg      <= {deb_reg[DEB_CYCLES-2:0], lk.core_reset};
      core_rst_reg <= deb_full;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Init clock tick and PMA init debounce
  logic                  ic_s1_reg;
  logic                  ic_s2_reg;
  logic                  ic_s3_reg;
  logic [DEB_CYCLES-1:0] pma_sh_reg;
  logic                  pma_rst_reg;
  // Init clock is slower than clk_i, so its rising edge is seen as a tick
  wire                   tick = ic_s2_reg & ~ic_s3_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ic_s1_reg   <= 1'b0;
      ic_s2_reg   <= 1'b0;
      ic_s3_reg   <= 1'b0;
      pma_sh_reg  <= '0;
      pma_rst_reg <= 1'b1;
    end else begin
      ic_s1_reg <= init_clk_i;
      ic_s2_reg <= ic_s1_reg;
      ic_s3_reg <= ic_s2_reg;
      if (tick) begin
        pma_sh_reg  <= {pma_sh_reg[DEB_CYCLES-2:0], lk.pma_init};
        pma_rst_reg <= &{pma_sh_reg[DEB_CYCLES-2:0], lk.pma_init};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transceiver reset sequencer, stepped by init clock ticks
  ukls_rst_st_t      rs_reg;
  ukls_rst_st_t      rs_next;
  logic [TICK_W-1:0] rcnt_reg;
  logic [TICK_W-1:0] rcnt_next;

  always_comb begin
    rs_next   = rs_reg;
    rcnt_next = rcnt_reg;
    if (tick) begin
      rcnt_next = rcnt_reg + 1'b1;
      case (rs_reg)
        RS_PMA: begin
          rcnt_next = '0;
          if (!pma_rst_reg) rs_next = RS_CLKGEN;
        end
        RS_CLKGEN: begin
          if (rcnt_reg == TICK_W'(CLKGEN_TICKS - 1)) begin
            rs_next   = RS_TX;
            rcnt_next = '0;
          end
        end
        RS_TX: begin
          if (rcnt_reg == TICK_W'(GT_TICKS - 1)) begin
            rs_next   = RS_RX;
            rcnt_next = '0;
          end
        end
        RS_RX: begin
          if (rcnt_reg == TICK_W'(GT_TICKS - 1)) rs_next = RS_DONE;
        end
        RS_DONE: rcnt_next = '0;
        default: rs_next = RS_PMA;
      endcase
      if (pma_rst_reg) rs_next = RS_PMA;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_reg        <= RS_PMA;
      rcnt_reg      <= '0;
      pcs_pma_rst_o <= 1'b1;
      clkgen_rst_o  <= 1'b1;
      gt_tx_rst_o   <= 1'b1;
      gt_rx_rst_o   <= 1'b1;
    end else begin
      rs_reg        <= rs_next;
      rcnt_reg      <= rcnt_next;
      // PCS and PMA held in reset
      pcs_pma_rst_o <= (rs_next == RS_PMA);
      clkgen_rst_o  <= (rs_next == RS_PMA) || (rs_next == RS_CLKGEN);
      gt_tx_rst_o   <= (rs_next != RS_RX) && (rs_next != RS_DONE);
      gt_rx_rst_o   <= (rs_next != RS_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs
  logic hard_reg;
  logic soft_reg;
  logic soft_prev_reg;
  logic chan_reg;
  logic [LANES-1:0] lane_up_reg;
  logic pdn_reg;
  wire  all_up    = &lane_ok_i;
  wire  chan_next = all_up & ~hard_reg & (rs_reg == RS_DONE);

  always_ff @(posedge clk_i) begin
    if (rst_i || core_rst_reg) begin
      hard_reg      <= 1'b0;
      soft_reg      <= 1'b0;
      soft_prev_reg <= 1'b0;
      chan_reg      <= 1'b0;
      lane_up_reg   <= '0;
    end else begin
      if (hard_evt_i) hard_reg <= 1'b1;
      soft_prev_reg <= soft_evt_i;
      soft_reg      <= soft_evt_i & ~soft_prev_reg;
      chan_reg      <= chan_next;
      lane_up_reg   <= lane_ok_i;
    end
  end

  // Power-down bypasses the core reset so the transceiver can sleep at any time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pdn_reg <= 1'b0;
    end else begin
      pdn_reg <= lk.power_down;
    end
  end

  assign lk.hard_err   = hard_reg;
  assign lk.soft_err   = soft_reg;
  assign lk.channel_up = chan_reg;
  assign lk.lane_up    = lane_up_reg;
  assign gt_pdn_o      = pdn_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit user K path
  logic          krdy_reg;
  logic          drdy_reg;
  logic          txv_reg;
  logic [LW-1:0] txd_reg;
  wire  fire       = lk.k_tx_valid & krdy_reg;
  // ready only when lane can take it
  // ready comes before any data moves
  // Built on chan_next so a hard error drops ready and channel_up on one edge
  wire  krdy_next  = TX_PRESENT & chan_next & lk.k_tx_valid & ~krdy_reg & ~lane_busy_i;
  // normal data ready yields to K ready
  wire  drdy_next  = chan_next & ~lane_busy_i & ~krdy_next;

  always_ff @(posedge clk_i) begin
    if (rst_i || core_rst_reg) begin
      krdy_reg <= 1'b0;
      drdy_reg <= 1'b0;
      txv_reg  <= 1'b0;
      txd_reg  <= '0;
    end else begin
      krdy_reg <= krdy_next;
      drdy_reg <= drdy_next;
      txv_reg  <= fire;
      if (fire) txd_reg <= lk.k_tx_data;
    end
  end

  assign lk.k_tx_ready = krdy_reg;
  assign lk.data_ready = drdy_reg;
  assign lane_tx_vld_o = txv_reg;
  assign lane_tx_dat_o = txd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Receive user K path
  logic [LW-1:0] rx_fmt;
  logic          rxv_reg;
  logic [LW-1:0] rxd_reg;
  // nothing delivered before all lanes up
  wire           rx_take = RX_PRESENT & lane_rx_vld_i & all_up & chan_reg;

  // zero top nibble on every lane
  for (genvar l = 0; l < LANES; l++) begin : g_rx_lane
    assign rx_fmt[l*64 +: 64] = {K_TOP_NIB, lane_rx_dat_i[l*64 +: 60]};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || core_rst_reg) begin
      rxv_reg <= 1'b0;
      rxd_reg <= '0;
    end else begin
      rxv_reg <= rx_take;
      if (rx_take) rxd_reg <= rx_fmt;
    end
  end

  assign lk.k_rx_valid = rxv_reg;
  assign lk.k_rx_data  = rxd_reg;

endmodule // ukls_dev

// ---- verilog/ukls_pkg.sv ----
// Shared constants and types for the user K-block and link status block
package ukls_pkg;
  // Lane count and bus widths
  localparam int LANES = 1;
  localparam int LW    = 64 * LANES;
  localparam int PAY_W = 56;
  localparam int BLK_TYPES = 9;
  localparam logic [3:0] K_TOP_NIB = 4'h0;
  // Build options: a simplex build clears one of these
  localparam bit TX_PRESENT = 1'b1;
  localparam bit RX_PRESENT = 1'b1;
  // Reset debounce and reset sequencing, in clock or init-clock ticks
  localparam int DEB_CYCLES   = 6;
  localparam int CLKGEN_TICKS = 4;
  localparam int GT_TICKS     = 4;
  localparam int TICK_W       = 3;
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TXLO   = 8'h04;
  localparam logic [7:0] REG_TXHI   = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0C;
  localparam logic [7:0] REG_RXLO   = 8'h10;
  localparam logic [7:0] REG_RXHI   = 8'h14;
  localparam logic [7:0] REG_IRQ    = 8'h18;
  localparam logic [7:0] REG_MASK   = 8'h1C;
  // Control fields
  localparam int CTRL_GO       = 0;
  localparam int CTRL_NUM_LO   = 4;
  localparam int CTRL_CORE_RST = 8;
  localparam int CTRL_PMA      = 9;
  localparam int CTRL_PDN      = 10;
  // Interrupt status bits
  localparam int IRQ_RXK  = 0;
  localparam int IRQ_TXD  = 1;
  localparam int IRQ_SOFT = 2;
  localparam int IRQ_HARD = 3;
  localparam int IRQ_BADN = 4;
  localparam int IRQ_W    = 5;
  // Transceiver reset sequencer states
  typedef enum logic [2:0] {RS_PMA, RS_CLKGEN, RS_TX, RS_RX, RS_DONE} ukls_rst_st_t;
endpackage : ukls_pkg

// ---- verilog/ukls_if.sv ----
// Interface joining the device end and the user application end
interface ukls_if;
  import ukls_pkg::*;
  logic                 k_tx_valid;
  logic [LW-1:0]        k_tx_data;
  logic                 k_tx_ready;
  logic                 data_ready;
  logic                 k_rx_valid;
  logic [LW-1:0]        k_rx_data;
  logic                 channel_up;
  logic [LANES-1:0]     lane_up;
  logic                 hard_err;
  logic                 soft_err;
  logic                 core_reset;
  logic                 pma_init;
  logic                 power_down;

  modport dev (
    input  k_tx_valid, k_tx_data, core_reset, pma_init, power_down,
    output k_tx_ready, data_ready, k_rx_valid, k_rx_data,
    output channel_up, lane_up, hard_err, soft_err
  );
  modport app (
    output k_tx_valid, k_tx_data, core_reset, pma_init, power_down,
    input  k_tx_ready, data_ready, k_rx_valid, k_rx_data,
    input  channel_up, lane_up, hard_err, soft_err
  );
endinterface : ukls_if

// ---- verilog/ukls_app.sv ----
// User application end: Wishbone register front end driving user K traffic
module ukls_app
  import ukls_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq_o,
  // Device side
  ukls_if.app              lk
);
  import ukls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic              ack_reg;
  logic [31:0]       rdat_reg;
  logic [3:0]        num_reg;
  logic              crst_reg;
  logic              pma_reg;
  logic              pdn_reg;
  logic [PAY_W-1:0]  pay_reg;
  logic              kv_reg;
  logic [LW-1:0]     kd_reg;
  logic [63:0]       rx_reg;
  logic [IRQ_W-1:0]  ist_reg;
  logic [IRQ_W-1:0]  msk_reg;
  logic              hard_prev_reg;
  logic              irq_reg;
  logic [31:0]       rd_mux;

  wire        acc   = wb_cyc_i & wb_stb_i;
  wire        wr    = acc & ack_reg & wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wr_ctrl = wr && (wb_adr_i == REG_CTRL);
  wire        wr_irq  = wr && (wb_adr_i == REG_IRQ);
  wire        go      = wr_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_GO];
  wire [3:0]  go_num  = wb_dat_i[CTRL_NUM_LO +: 4];
  // only the nine defined block types
  wire        num_ok  = (go_num < 4'(BLK_TYPES));
  wire        fire    = kv_reg & lk.k_tx_ready;
  wire        hard_up = lk.hard_err & ~hard_prev_reg;
  wire [IRQ_W-1:0] ev = {go & ~num_ok, hard_up, lk.soft_err, fire, lk.k_rx_valid};
  wire [IRQ_W-1:0] w1c = wr_irq ? (wb_dat_i[IRQ_W-1:0] & bmask[IRQ_W-1:0]) : '0;
  wire [31:0] pay_lo  = (pay_reg[31:0] & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] pay_hi  = ({8'h00, pay_reg[PAY_W-1:32]} & ~bmask) | (wb_dat_i & bmask);

  always_comb begin
    case (wb_adr_i)
      REG_CTRL: rd_mux = {21'h0, pdn_reg, pma_reg, crst_reg, num_reg, 4'h0};
      REG_TXLO: rd_mux = pay_reg[31:0];
      REG_TXHI: rd_mux = {8'h00, pay_reg[PAY_W-1:32]};
      REG_STAT: rd_mux = {28'h0, kv_reg, lk.hard_err, &lk.lane_up, lk.channel_up};
      REG_RXLO: rd_mux = rx_reg[31:0];
      REG_RXHI: rd_mux = rx_reg[63:32];
      REG_IRQ:  rd_mux = {{(32-IRQ_W){1'b0}}, ist_reg};
      REG_MASK: rd_mux = {{(32-IRQ_W){1'b0}}, msk_reg};
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
      num_reg  <= '0;
      crst_reg <= 1'b0;
      pma_reg  <= 1'b0;
      pdn_reg  <= 1'b0;
      pay_reg  <= '0;
      msk_reg  <= '0;
    end else begin
      // One wait state: ack follows the strobe and drops the next cycle
      ack_reg <= acc & ~ack_reg;
      if (acc & ~ack_reg) rdat_reg <= rd_mux;
      if (wr_ctrl && wb_sel_i[0]) num_reg <= go_num;
      if (wr_ctrl && wb_sel_i[1]) begin
        crst_reg <= wb_dat_i[CTRL_CORE_RST];
        pma_reg  <= wb_dat_i[CTRL_PMA];
        pdn_reg  <= wb_dat_i[CTRL_PDN];
      end
      if (wr && wb_adr_i == REG_TXLO) pay_reg[31:0] <= pay_lo;
      if (wr && wb_adr_i == REG_TXHI) pay_reg[PAY_W-1:32] <= pay_hi[PAY_W-33:0];
      if (wr && wb_adr_i == REG_MASK) msk_reg <= (wb_dat_i[IRQ_W-1:0] & bmask[IRQ_W-1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User K transmit request and receive capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kv_reg        <= 1'b0;
      kd_reg        <= '0;
      rx_reg        <= '0;
      ist_reg       <= '0;
      hard_prev_reg <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      // valid raised only with a full block
      if (go && num_ok && !kv_reg) begin
        kv_reg <= 1'b1;
        kd_reg <= {LANES{K_TOP_NIB, go_num, pay_reg}};
      // held until the device is ready
      end else if (fire) begin
        kv_reg <= 1'b0;
      end
      if (lk.k_rx_valid) rx_reg <= lk.k_rx_data[63:0];
      hard_prev_reg <= lk.hard_err;
      // A new event wins over a same-cycle clear
      ist_reg <= (ist_reg & ~w1c) | ev;
      irq_reg <= |(((ist_reg & ~w1c) | ev) & msk_reg);
    end
  end

  assign wb_ack_o      = ack_reg;
  assign wb_dat_o      = rdat_reg;
  assign irq_o         = irq_reg;
  assign lk.k_tx_valid = kv_reg;
  assign lk.k_tx_data  = kd_reg;
  assign lk.core_reset = crst_reg;
  assign lk.pma_init   = pma_reg;
  assign lk.power_down = pdn_reg;

endmodule // ukls_app

// ---- bench/ukls_checker.sv ----
// Concurrent checks on the signals joining the device and application ends
module ukls_checker
  import ukls_pkg::*;
(
  // Clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // Interface signals
  input wire logic             k_tx_valid,
  input wire logic [LW-1:0]    k_tx_data,
  input wire logic             k_tx_ready,
  input wire logic             data_ready,
  input wire logic             k_rx_valid,
  input wire logic [LW-1:0]    k_rx_data,
  input wire logic             channel_up,
  input wire logic [LANES-1:0] lane_up,
  input wire logic             hard_err,
  input wire logic             soft_err,
  input wire logic             core_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  property p_excl; k_tx_ready |-> !data_ready; endproperty
  a_excl: assert property (p_excl)
    else $error("normal data ready high together with K ready");
  property p_hold; k_tx_valid && !k_tx_ready |=> k_tx_valid && $stable(k_tx_data); endproperty
  a_hold: assert property (p_hold)
    else $error("K block withdrawn or changed before it was taken");
  property p_rdy_vld; k_tx_ready |-> k_tx_valid; endproperty
  a_rdy_vld: assert property (p_rdy_vld)
    else $error("K ready given with no block offered");
  property p_rdy_gap; k_tx_ready |=> !k_tx_ready; endproperty
  a_rdy_gap: assert property (p_rdy_gap)
    else $error("K ready high two cycles running");
  property p_rdy_chan; k_tx_ready |-> channel_up; endproperty
  a_rdy_chan: assert property (p_rdy_chan)
    else $error("K ready while channel down");
  property p_rx_nib; k_rx_valid |-> k_rx_data[63:60] == K_TOP_NIB; endproperty
  a_rx_nib: assert property (p_rx_nib)
    else $error("received K word top nibble not zero");
  property p_rx_gate; k_rx_valid |-> $past(channel_up); endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("K block delivered while channel down");
  property p_chan_lanes; channel_up |-> &lane_up; endproperty
  a_chan_lanes: assert property (p_chan_lanes)
    else $error("channel up with a lane down");
  property p_soft; soft_err |=> !soft_err; endproperty
  a_soft: assert property (p_soft)
    else $error("soft error longer than one cycle");
  property p_hard; hard_err && !core_reset |=> hard_err; endproperty
  a_hard: assert property (p_hard)
    else $error("hard error dropped without core reset");
  property p_core_clr; core_reset [*8] |=> !hard_err; endproperty
  a_core_clr: assert property (p_core_clr)
    else $error("long core reset did not clear hard error");
endmodule // ukls_checker

// ---- bench/tb_user_k_block_and_link_status.sv ----
// Testbench: Wishbone-driven K traffic and status across both ends
module tb_user_k_block_and_link_status;
  timeunit 1ns;
  timeprecision 1ps;
  import ukls_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic [2:0]       div = 3'h0;
  logic [LANES-1:0] lane_ok = '0;
  logic             lane_busy = 1'b0;
  logic             rx_vld = 1'b0;
  logic [LW-1:0]    rx_dat = '0;
  logic             hard_evt = 1'b0;
  logic             soft_evt = 1'b0;
  logic             cyc = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h0;
  logic [31:0]      rdat;
  logic             ack;
  logic             irq;
  logic             tx_vld;
  logic [LW-1:0]    tx_dat;
  logic             pdn;
  logic             pma_rst;
  logic [2:0]       seq_rst;
  int               miscompares = 0;
  int               check_count = 0;
  int               tx_cnt = 0;
  int               rx_cnt = 0;
  int               soft_cnt = 0;
  logic [31:0]      lo;
  //////////////////////////////////////////////////////////////////////////////
  always #20 clk_i = ~clk_i;
  // Init clock at an eighth of the user clock, well inside the sync limit
  always @(posedge clk_i) div <= div + 3'h1;
  always @(posedge clk_i) begin
    if (tx_vld === 1'b1) tx_cnt <= tx_cnt + 1;
    if (ukls_if_inst.k_rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
    if (ukls_if_inst.soft_err === 1'b1) soft_cnt <= soft_cnt + 1;
  end
  ukls_if ukls_if_inst ();
  ukls_dev ukls_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .lk(ukls_if_inst.dev),
    .init_clk_i(div[2]), .lane_ok_i(lane_ok), .lane_busy_i(lane_busy),
    .lane_rx_vld_i(rx_vld), .lane_rx_dat_i(rx_dat), .hard_evt_i(hard_evt),
    .soft_evt_i(soft_evt), .lane_tx_vld_o(tx_vld), .lane_tx_dat_o(tx_dat),
    .gt_pdn_o(pdn), .pcs_pma_rst_o(pma_rst), .clkgen_rst_o(seq_rst[0]),
    .gt_tx_rst_o(seq_rst[1]), .gt_rx_rst_o(seq_rst[2]));
  ukls_app ukls_app_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .lk(ukls_if_inst.app));
  ukls_checker ukls_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .k_tx_valid(ukls_if_inst.k_tx_valid), .k_tx_data(ukls_if_inst.k_tx_data),
    .k_tx_ready(ukls_if_inst.k_tx_ready), .data_ready(ukls_if_inst.data_ready),
    .k_rx_valid(ukls_if_inst.k_rx_valid), .k_rx_data(ukls_if_inst.k_rx_data),
    .channel_up(ukls_if_inst.channel_up), .lane_up(ukls_if_inst.lane_up),
    .hard_err(ukls_if_inst.hard_err), .soft_err(ukls_if_inst.soft_err),
    .core_reset(ukls_if_inst.core_reset));
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stays put until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk({32'h0, q}, {32'h0, e});
  endtask
  task automatic wait_on(input bit chan, input int tgt);
    int n;
    n = 0;
    while (n < 400 && (chan ? ukls_if_inst.channel_up !== 1'b1 : tx_cnt < tgt)) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic send_rx(input logic [63:0] a, input logic [63:0] b);
    @(posedge clk_i);
    rx_vld <= 1'b1;
    rx_dat <= a;
    @(posedge clk_i);
    rx_dat <= b;
    @(posedge clk_i);
    rx_vld <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(REG_STAT, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0);
    send_rx(64'h0111_2222_3333_4444, 64'h0555_6666_7777_8888);
    chk(64'(rx_cnt), 64'h0);
    lane_ok <= '1;
    wait_on(1'b1, 0);
    rd_chk(REG_STAT, 32'h3);
    chk({63'h0, ukls_if_inst.data_ready}, 64'h1);
    chk({61'h0, seq_rst}, 64'h0);
    $display("test bring_up done");
    wr(REG_MASK, 32'h1F);
    lane_busy <= 1'b1;
    for (int n = 0; n <= BLK_TYPES; n++) begin
      lo = {28'hA5A5_F0E, 4'(n)};
      wr(REG_TXLO, lo);
      wr(REG_TXHI, 32'h00C3_5A96);
      wr(REG_CTRL, 32'(n * 16 + 1));
      if (n == 0) begin
        repeat (10) @(posedge clk_i);
        chk(64'(tx_cnt), 64'h0);
        rd_chk(REG_STAT, 32'hB);
        lane_busy <= 1'b0;
      end
      if (n == BLK_TYPES) begin
        repeat (10) @(posedge clk_i);
        chk(64'(tx_cnt), 64'(n));
        rd_chk(REG_IRQ, 32'h10);
      end else begin
        wait_on(1'b0, n + 1);
        chk(tx_dat, {4'h0, 4'(n), 24'hC3_5A96, lo});
        rd_chk(REG_IRQ, 32'h2);
      end
      chk({63'h0, irq}, 64'h1);
      wr(REG_IRQ, 32'h1F);
      rd_chk(REG_IRQ, 32'h0);
    end
    $display("test k_transmit done");
    // Back to back, with the top nibble set so its clearing shows
    send_rx(64'hF123_4567_89AB_CDEF, 64'hF8FE_DCBA_7654_3210);
    chk(64'(rx_cnt), 64'h2);
    rd_chk(REG_RXLO, 32'h7654_3210);
    rd_chk(REG_RXHI, 32'h08FE_DCBA);
    rd_chk(REG_IRQ, 32'h1);
    wr(REG_IRQ, 32'h1F);
    $display("test k_receive done");
    @(posedge clk_i);
    soft_evt <= 1'b1;
    repeat (3) @(posedge clk_i);
    soft_evt <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(64'(soft_cnt), 64'h1);
    rd_chk(REG_IRQ, 32'h4);
    wr(REG_IRQ, 32'h1F);
    @(posedge clk_i);
    hard_evt <= 1'b1;
    @(posedge clk_i);
    hard_evt <= 1'b0;
    // A core reset pulse shorter than the debounce must not clear it
    wr(REG_CTRL, 32'h100);
    wr(REG_CTRL, 32'h0);
    rd_chk(REG_STAT, 32'h6);
    rd_chk(REG_IRQ, 32'h8);
    wr(REG_CTRL, 32'h100);
    repeat (10) @(posedge clk_i);
    wr(REG_CTRL, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({63'h0, ukls_if_inst.hard_err}, 64'h0);
    wait_on(1'b1, 0);
    wr(REG_IRQ, 32'h1F);
    $display("test errors done");
    wr(REG_CTRL, 32'h400);
    repeat (2) @(posedge clk_i);
    chk({63'h0, pdn}, 64'h1);
    wr(REG_CTRL, 32'h200);
    repeat (80) @(posedge clk_i);
    chk({62'h0, pma_rst, ukls_if_inst.channel_up}, 64'h2);
    chk({61'h0, seq_rst}, 64'h7);
    wr(REG_CTRL, 32'h0);
    wait_on(1'b1, 0);
    chk({60'h0, pma_rst, seq_rst}, 64'h0);
    $display("test resets done");
    give_verdict();
  end
endmodule // tb_user_k_block_and_link_status
